// ===== mbs_pkg.sv
/*
 * Constants for the framing server: header layout, function codes,
 * exception codes, size limits and the framer state encoding.
 * Assumes nothing of its surroundings; imported by the framer modules.
 */
package mbs_pkg;
    localparam int          HDR_LEN       = 7;            // Header bytes ahead of the PDU
    localparam int          PDU_MAX       = 253;          // Largest PDU in bytes
    localparam int          ADU_MAX       = 260;          // Largest frame in bytes
    localparam logic [15:0] TCP_PORT      = 16'h01f6;     // Port 502
    localparam logic [15:0] PROTO_ID      = 16'h0000;     // Protocol identifier value
    localparam logic [7:0]  FC_READ_HOLD  = 8'h03;
    localparam logic [7:0]  FC_EXC_FLAG   = 8'h80;
    localparam logic [7:0]  EXC_ILL_FUNC  = 8'h01;
    localparam logic [7:0]  EXC_ILL_ADDR  = 8'h02;
    localparam logic [7:0]  EXC_ILL_VALUE = 8'h03;
    localparam logic [7:0]  EXC_DEV_FAIL  = 8'h04;
    localparam logic [15:0] QTY_MIN       = 16'h0001;
    localparam logic [15:0] QTY_MAX       = 16'h007d;     // 125 registers
    localparam logic [7:0]  UNIT_PLAIN    = 8'h00;
    localparam logic [7:0]  UNIT_ANY      = 8'hff;
    localparam logic [15:0] BCAST_UNIT    = 16'h0000;     // Unused marker width guard
    localparam logic [7:0]  RD_REQ_PDU    = 8'h05;        // Read request PDU length
    localparam logic [15:0] EXC_LEN       = 16'h0003;     // Unit + code + exception
    localparam logic [8:0]  ADU_MAX_W     = 9'h104;       // 260 as a count
    localparam logic [15:0] LEN_MAX       = 16'h00fe;     // Unit byte plus 253

    typedef enum logic [2:0] {
        MBS_IDLE = 3'b000,
        MBS_RECV = 3'b001,
        MBS_SKIP = 3'b010,
        MBS_FETCH = 3'b011,
        MBS_SEND = 3'b100
    } mbs_state_t;
endpackage : mbs_pkg

// ===== mbs_req_check.sv
/*
 * Request checker: classifies a received PDU head as a read of holding
 * registers, or picks the exception code to return.
 * Assumes fields are already assembled most significant byte first.
 */
`timescale 1ns/10ps
module mbs_req_check
    import mbs_pkg::*;
(
    input  wire logic [7:0]  func_code,
    input  wire logic [15:0] start_addr,
    input  wire logic [15:0] reg_qty,
    input  wire logic [15:0] pdu_len,
    input  wire logic        addr_ok,
    output logic             is_read,
    output logic [7:0]       exc_code
);
    logic        fc_public;
    logic [16:0] last_addr;

    // Public function code ranges
    assign fc_public = (func_code >= 8'h01 && func_code <= 8'h40) ||
                       (func_code >= 8'h49 && func_code <= 8'h63) ||
                       (func_code >= 8'h6f && func_code <= 8'h7f);
    assign last_addr = {1'b0, start_addr} + {1'b0, reg_qty} - 17'h00001;

    // Exception selection, function first, then PDU length and quantity, then address
    always_comb begin
        is_read  = 1'b0;
        exc_code = 8'h00;
        if (func_code != FC_READ_HOLD || !fc_public) begin
            exc_code = EXC_ILL_FUNC;
        end else if (pdu_len != {8'h00, RD_REQ_PDU}) begin
            exc_code = EXC_ILL_VALUE;
        end else if (reg_qty < QTY_MIN || reg_qty > QTY_MAX) begin
            exc_code = EXC_ILL_VALUE;
        end else if (last_addr[16] || !addr_ok) begin
            exc_code = EXC_ILL_ADDR;
        end else begin
            is_read = 1'b1;
        end
    end
endmodule : mbs_req_check

// ===== mbs_adu_server.sv
/*
 * Framing server: takes one request frame as a byte stream, checks it,
 * fetches registers from a user read port and streams the answer frame.
 * Assumes the network stack delivers frames of the server port, marking
 * the first byte with rx_first, and that reg_rdata is valid while reg_rd is high.
 */
`timescale 1ns/10ps
// Overview of operation
// - A frame is a seven-byte header followed by function code and data.
// - The answer repeats the two transaction identifier bytes of the request.
// - The protocol identifier is zero; the server echoes what arrived.
// - Length counts unit, function and data bytes; server computes its own.
// - The unit identifier comes back unchanged.
// - Frames ride in TCP data on port 502.
// - Multi-byte values travel most significant byte first.
// - Exception answer is function code plus 80 then one code byte.
// - PDU at most 253 bytes, whole frame at most 260.
// - Function code zero invalid; 128 to 255 only mark exceptions.
// - Only public function codes are served.
// - Register addresses are zero-based.
// - Read answer: code 03, byte count twice quantity, registers high first.
// - Message end known from function code or embedded byte count.
// - No serial address and no checksum inside the PDU.
// - Failed read answers 83 and an exception code 01 to 04.
// - Never initiate; answer addressed requests, stay silent on broadcasts.
module mbs_adu_server
    import mbs_pkg::*;
(
    input  wire logic        ref_clk,
    input  wire logic        resetn,
    input  wire logic        rx_valid,
    input  wire logic [7:0]  rx_data,
    input  wire logic        rx_first,
    input  wire logic        rx_bcast,
    output logic             tx_valid_ff,
    output logic [7:0]       tx_data_ff,
    output logic             tx_last_ff,
    input  wire logic        tx_ready,
    output logic             reg_rd_ff,
    output logic [15:0]      reg_addr_ff,
    input  wire logic [15:0] reg_rdata,
    input  wire logic        reg_addr_ok,
    output logic             busy_ff,
    output logic             frame_err_ff
);
    mbs_state_t  state_ff;
    logic [8:0]  cnt_ff;
    logic [15:0] tid_ff;
    logic [15:0] pid_ff;
    logic [15:0] len_ff;
    logic [7:0]  unit_ff;
    logic [7:0]  fc_ff;
    logic [15:0] start_ff;
    logic [15:0] qty_ff;
    logic        bcast_ff;
    logic [7:0]  resp_ff [0:ADU_MAX-1];
    logic [8:0]  resp_len_ff;
    logic [8:0]  tx_idx_ff;
    logic [6:0]  fetch_ff;
    logic        rd_pend_ff;
    logic        is_read;
    logic [7:0]  exc_code;
    logic [15:0] pdu_len;
    logic [15:0] nxt_len;
    logic        hdr_done;
    logic        tx_take;

    assign pdu_len  = len_ff - 16'h0001;
    assign hdr_done = rx_valid && (cnt_ff == 9'(ADU_MAX - 1) || cnt_ff == 9'(len_ff + 16'h0005));
    assign tx_take  = tx_valid_ff && tx_ready;
    // Server length: unit, function, count and two bytes per register on a read; EXC_LEN on an exception
    assign nxt_len  = is_read ? 16'(16'h0003 + {qty_ff[14:0], 1'b0}) : EXC_LEN;

    mbs_req_check u_check (
        .func_code  (fc_ff),
        .start_addr (start_ff),
        .reg_qty    (qty_ff),
        .pdu_len    (pdu_len),
        .addr_ok    (reg_addr_ok),
        .is_read    (is_read),
        .exc_code   (exc_code)
    );

    // Sequencing of receive, fetch and transmit; idle until a request arrives
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            state_ff <= MBS_IDLE;
        end else begin
            case (state_ff)
                MBS_IDLE: if (rx_valid && rx_first) state_ff <= MBS_RECV;
                MBS_RECV: begin
                    if (rx_valid && rx_first) state_ff <= MBS_RECV;
                    else if (rx_valid && cnt_ff == 9'h005 && {len_ff[15:8], rx_data} > LEN_MAX)
                        state_ff <= MBS_SKIP;
                    else if (rx_valid && cnt_ff == 9'h005 && {len_ff[15:8], rx_data} < 16'h0002)
                        state_ff <= MBS_SKIP;
                    else if (hdr_done && cnt_ff >= 9'h007) state_ff <= MBS_FETCH;
                end
                MBS_SKIP: if (hdr_done || (rx_valid && rx_first)) state_ff <= MBS_IDLE;
                MBS_FETCH: begin
                    if (bcast_ff) state_ff <= MBS_IDLE;
                    else if (!is_read || (fetch_ff == qty_ff[6:0] && !rd_pend_ff)) state_ff <= MBS_SEND;
                end
                MBS_SEND: if (tx_take && tx_last_ff) state_ff <= MBS_IDLE;
                default: state_ff <= MBS_IDLE;
            endcase
        end
    end

    // Byte counter across the frame, header first
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            cnt_ff <= 9'h000;
        end else if (rx_valid && rx_first) begin
            cnt_ff <= 9'h001;
        end else if (rx_valid && (state_ff == MBS_RECV || state_ff == MBS_SKIP)) begin
            cnt_ff <= cnt_ff + 9'h001;
        end
    end

    // Header and PDU field capture, most significant byte first
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            tid_ff   <= 16'h0000;
            pid_ff   <= 16'h0000;
            len_ff   <= 16'h0000;
            unit_ff  <= 8'h00;
            fc_ff    <= 8'h00;
            start_ff <= 16'h0000;
            qty_ff   <= 16'h0000;
            bcast_ff <= 1'b0;
        end else if (rx_valid && rx_first) begin
            fc_ff    <= 8'h00;
            start_ff <= 16'h0000;
            qty_ff   <= 16'h0000;
            bcast_ff <= rx_bcast;
            tid_ff[15:8] <= rx_data;
        end else if (rx_valid && state_ff == MBS_RECV) begin
            case (cnt_ff)
                9'h001: tid_ff[7:0]    <= rx_data;
                9'h002: pid_ff[15:8]   <= rx_data;
                9'h003: pid_ff[7:0]    <= rx_data;
                9'h004: len_ff[15:8]   <= rx_data;
                9'h005: len_ff[7:0]    <= rx_data;
                9'h006: unit_ff        <= rx_data;
                9'h007: fc_ff          <= rx_data;
                9'h008: start_ff[15:8] <= rx_data;
                9'h009: start_ff[7:0]  <= rx_data;
                9'h00a: qty_ff[15:8]   <= rx_data;
                9'h00b: qty_ff[7:0]    <= rx_data;
                default: fc_ff         <= fc_ff;
            endcase
        end
    end

    // Register fetch: one read per register, data written high byte first
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            reg_rd_ff   <= 1'b0;
            reg_addr_ff <= 16'h0000;
            fetch_ff    <= 7'h00;
            rd_pend_ff  <= 1'b0;
        end else if (state_ff != MBS_FETCH) begin
            reg_rd_ff   <= 1'b0;
            reg_addr_ff <= start_ff;
            fetch_ff    <= 7'h00;
            rd_pend_ff  <= 1'b0;
        end else begin
            reg_rd_ff  <= 1'b0;
            rd_pend_ff <= 1'b0;
            if (rd_pend_ff) begin
                fetch_ff    <= fetch_ff + 7'h01;
                reg_addr_ff <= reg_addr_ff + 16'h0001;
            end else if (is_read && !bcast_ff && fetch_ff != qty_ff[6:0]) begin
                reg_rd_ff  <= 1'b1;
                rd_pend_ff <= 1'b1;
            end
        end
    end

    // Answer image: header echoed, length recomputed, normal or exception PDU
    always_ff @(posedge ref_clk) begin
        if (state_ff == MBS_FETCH) begin
            resp_ff[0] <= tid_ff[15:8];
            resp_ff[1] <= tid_ff[7:0];
            resp_ff[2] <= pid_ff[15:8];
            resp_ff[3] <= pid_ff[7:0];
            resp_ff[4] <= nxt_len[15:8];
            resp_ff[5] <= nxt_len[7:0];
            resp_ff[6] <= unit_ff;
            if (is_read) begin
                resp_ff[7] <= FC_READ_HOLD;
                resp_ff[8] <= {qty_ff[6:0], 1'b0};
            end else begin
                resp_ff[7] <= fc_ff | FC_EXC_FLAG;
                resp_ff[8] <= exc_code;
            end
            if (rd_pend_ff) begin
                resp_ff[9'(9 + 2 * fetch_ff)]  <= reg_rdata[15:8];
                resp_ff[9'(10 + 2 * fetch_ff)] <= reg_rdata[7:0];
            end
        end
    end

    // Answer length in bytes; no checksum is appended
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            resp_len_ff <= 9'h000;
        end else if (state_ff == MBS_FETCH) begin
            resp_len_ff <= 9'(nxt_len + 16'h0006);
        end
    end

    // Byte stream out, held until the sink takes it
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            tx_valid_ff <= 1'b0;
            tx_data_ff  <= 8'h00;
            tx_last_ff  <= 1'b0;
            tx_idx_ff   <= 9'h000;
        end else if (state_ff != MBS_SEND) begin
            tx_valid_ff <= 1'b0;
            tx_last_ff  <= 1'b0;
            tx_idx_ff   <= 9'h000;
        end else if (!tx_valid_ff || tx_take) begin
            if (tx_take && tx_last_ff) begin
                tx_valid_ff <= 1'b0;
                tx_last_ff  <= 1'b0;
            end else begin
                tx_valid_ff <= 1'b1;
                tx_data_ff  <= resp_ff[tx_idx_ff];
                tx_last_ff  <= (tx_idx_ff == resp_len_ff - 9'h001);
                tx_idx_ff   <= tx_idx_ff + 9'h001;
            end
        end
    end

    // Status: busy while a frame is handled, error on a header length above 254 or below 2
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            busy_ff      <= 1'b0;
            frame_err_ff <= 1'b0;
        end else begin
            busy_ff <= (state_ff != MBS_IDLE);
            if (rx_valid && rx_first) begin
                frame_err_ff <= 1'b0;
            end else if (state_ff == MBS_SKIP) begin
                frame_err_ff <= 1'b1;
            end
        end
    end
endmodule : mbs_adu_server

// ===== mbs_adu_monitor.sv
/* Checker of the answer stream and register read port of the framing server.
   Bound to every server instance; sees only the server ports. */
`timescale 1ns/10ps
module mbs_adu_monitor (
    input wire logic        ref_clk,
    input wire logic        resetn,
    input wire logic        rx_valid,
    input wire logic [7:0]  rx_data,
    input wire logic        rx_first,
    input wire logic        rx_bcast,
    input wire logic        tx_valid_ff,
    input wire logic [7:0]  tx_data_ff,
    input wire logic        tx_last_ff,
    input wire logic        tx_ready,
    input wire logic        reg_rd_ff,
    input wire logic [15:0] reg_addr_ff,
    input wire logic [15:0] reg_rdata,
    input wire logic        reg_addr_ok,
    input wire logic        busy_ff,
    input wire logic        frame_err_ff
);
    logic bcast_ff;
    // Remembers whether the frame in progress is a broadcast
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) bcast_ff <= 1'b0;
        else if (rx_valid && rx_first) bcast_ff <= rx_bcast;
    end
    default clocking mbs_cb @(posedge ref_clk); endclocking
    default disable iff (!resetn);
    sequence byte_stall; tx_valid_ff && !tx_ready; endsequence
    sequence last_taken; tx_valid_ff && tx_last_ff && tx_ready; endsequence
    sequence rd_pair; reg_rd_ff ##2 reg_rd_ff; endsequence
    tx_hold_a: assert property (byte_stall |=> tx_valid_ff && $stable(tx_data_ff) && $stable(tx_last_ff))
        else $error("answer byte changed while stalled");
    answer_end_a: assert property (last_taken |=> !tx_valid_ff)
        else $error("answer went on after its last byte");
    last_valid_a: assert property (tx_last_ff |-> tx_valid_ff)
        else $error("last mark without a valid byte");
    bcast_quiet_a: assert property (bcast_ff |-> !tx_valid_ff)
        else $error("answer sent to a broadcast");
    err_quiet_a: assert property (frame_err_ff |-> !tx_valid_ff)
        else $error("answer sent for a bad length");
    tx_caused_a: assert property ($rose(tx_valid_ff) |-> busy_ff)
        else $error("answer started outside a frame");
    rd_pulse_a: assert property (reg_rd_ff |=> !reg_rd_ff)
        else $error("read request longer than one cycle");
    rd_step_a: assert property (rd_pair |-> reg_addr_ff == $past(reg_addr_ff, 2) + 16'h0001)
        else $error("register address did not step by one");
    rd_busy_a: assert property (reg_rd_ff |-> busy_ff)
        else $error("register read outside a frame");
endmodule : mbs_adu_monitor

bind mbs_adu_server mbs_adu_monitor u_mbs_adu_monitor (.ref_clk, .resetn, .rx_valid, .rx_data, .rx_first,
    .rx_bcast, .tx_valid_ff, .tx_data_ff, .tx_last_ff, .tx_ready, .reg_rd_ff, .reg_addr_ff, .reg_rdata,
    .reg_addr_ok, .busy_ff, .frame_err_ff);

// ===== mbs_client_model.sv
/* Far-side model: answer sink that stalls one cycle in three, and a
   register store whose data follows the address within the read cycle. */
`timescale 1ns/10ps
module mbs_client_model (
    input  wire logic        ref_clk,
    input  wire logic        resetn,
    input  wire logic        reg_rd_ff,
    input  wire logic [15:0] reg_addr_ff,
    output logic             tx_ready,
    output logic [15:0]      reg_rdata
);
    logic [1:0] stall_ff;
    // Stall pattern of the sink
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) stall_ff <= 2'h0;
        else stall_ff <= (stall_ff == 2'h2) ? 2'h0 : stall_ff + 2'h1;
    end
    assign tx_ready = (stall_ff != 2'h2);
    // Register contents follow the zero-based address, valid while the read pulse stands
    assign reg_rdata = reg_addr_ff ^ 16'h5a3c;
endmodule : mbs_client_model

// ===== test_mbs_adu_server.sv
/* Self-checking bench of the framing server: reset, then table of requests,
   then broadcast, bad length and wrong PDU length by hand.
   Assumes the client model as register store and answer sink. */
`timescale 1ns/10ps
module test_mbs_adu_server;
    import mbs_pkg::*;
    typedef struct { logic [7:0] unit; logic [7:0] fc; logic [15:0] addr; logic [15:0] qty;
                     logic ok; logic [7:0] exc; } mbs_row_t;
    logic        ref_clk = 1'b0, resetn = 1'b0, rx_valid = 1'b0, rx_first = 1'b0, rx_bcast = 1'b0;
    logic [7:0]  rx_data = 8'h00;
    logic        reg_addr_ok = 1'b1, got_last = 1'b0;
    logic        tx_valid_ff, tx_last_ff, tx_ready, reg_rd_ff, busy_ff, frame_err_ff;
    logic [7:0]  tx_data_ff;
    logic [15:0] reg_addr_ff, reg_rdata;
    logic [7:0]  rxq[$];
    int          failures = 0, checks_done = 0;
    mbs_row_t rows [8] = '{'{8'h00, 8'h03, 16'h0068, 16'h0002, 1'b1, 8'h00}, '{8'hff, 8'h03, 16'h0000, 16'h007d, 1'b1, 8'h00},
        '{8'h00, 8'h03, 16'h0000, 16'h0000, 1'b1, 8'h03}, '{8'h00, 8'h03, 16'h0000, 16'h007e, 1'b1, 8'h03},
        '{8'h00, 8'h03, 16'hfff0, 16'h0010, 1'b0, 8'h02}, '{8'h00, 8'h04, 16'h0000, 16'h0001, 1'b1, 8'h01},
        '{8'hff, 8'h00, 16'h0000, 16'h0001, 1'b1, 8'h01}, '{8'h00, 8'h7f, 16'h0000, 16'h0001, 1'b1, 8'h01}};
    mbs_adu_server u_mbs_adu_server (.ref_clk(ref_clk), .resetn(resetn), .rx_valid(rx_valid), .rx_data(rx_data),
        .rx_first(rx_first), .rx_bcast(rx_bcast), .tx_valid_ff(tx_valid_ff), .tx_data_ff(tx_data_ff),
        .tx_last_ff(tx_last_ff), .tx_ready(tx_ready), .reg_rd_ff(reg_rd_ff), .reg_addr_ff(reg_addr_ff),
        .reg_rdata(reg_rdata), .reg_addr_ok(reg_addr_ok), .busy_ff(busy_ff), .frame_err_ff(frame_err_ff));
    mbs_client_model u_mbs_client_model (.ref_clk(ref_clk), .resetn(resetn), .reg_rd_ff(reg_rd_ff),
        .reg_addr_ff(reg_addr_ff), .tx_ready(tx_ready), .reg_rdata(reg_rdata));
    // Clock at 50 MHz
    initial begin
        forever #10 ref_clk = ~ref_clk;
    end
    // Collects every answer byte the sink takes
    always @(posedge ref_clk) begin
        if (tx_valid_ff === 1'b1 && tx_ready === 1'b1) begin
            rxq.push_back(tx_data_ff);
            if (tx_last_ff === 1'b1) got_last = 1'b1;
        end
    end
    task automatic conclude;
        $display("checks %0d mismatches %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : conclude
    task automatic cmp(input string what, input logic [15:0] exp, input logic [15:0] seen);
        checks_done++;
        if (seen !== exp) begin
            $display("wrong value %s expected %h seen %h", what, exp, seen);
            failures++;
        end
    endtask : cmp
    // Sends one frame of 6 + len bytes, fields most significant byte first
    task automatic send_req(input logic [15:0] tid, input logic [7:0] unit, input logic [7:0] fc,
                            input logic [15:0] addr, input logic [15:0] qty, input logic [15:0] len, input logic bc);
        logic [7:0] q [13];
        q = '{tid[15:8], tid[7:0], 8'h00, 8'h00, len[15:8], len[7:0], unit, fc, addr[15:8], addr[7:0],
              qty[15:8], qty[7:0], 8'h00};
        rxq.delete();
        got_last = 1'b0;
        for (int i = 0; i < 6 + len; i++) begin
            @(posedge ref_clk);
            #1 rx_valid = 1'b1;
            rx_data = q[i];
            rx_first = (i == 0);
            rx_bcast = bc;
        end
        @(posedge ref_clk);
        #1 rx_valid = 1'b0;
        rx_first = 1'b0;
    endtask : send_req
    task automatic wait_done(input logic answer);
        for (int n = 0; n < 3000; n++) begin
            @(posedge ref_clk);
            #1;
            if (answer ? got_last : busy_ff === 1'b0) return;
        end
        $display("wait ran out");
        failures++;
        conclude();
    endtask : wait_done
    // Compares the collected answer with the frame the server owes
    task automatic check_ans(input logic [15:0] tid, input logic [7:0] unit, input logic [7:0] fc,
                             input logic [15:0] addr, input logic [15:0] qty, input logic [7:0] exc);
        logic [7:0]  eq[$];
        logic [15:0] ln, d;
        ln = (exc != 8'h00) ? EXC_LEN : 16'h0003 + 2 * qty;
        eq = '{tid[15:8], tid[7:0], 8'h00, 8'h00, ln[15:8], ln[7:0], unit};
        if (exc != 8'h00) eq = {eq, fc | FC_EXC_FLAG, exc};
        else eq = {eq, FC_READ_HOLD, qty[7:0] << 1};
        for (int i = 0; i < qty && exc == 8'h00; i++) begin
            d = (addr + i) ^ 16'h5a3c;
            eq = {eq, d[15:8], d[7:0]};
        end
        cmp("answer length", 16'(eq.size()), 16'(rxq.size()));
        for (int i = 0; i < eq.size() && i < rxq.size(); i++) cmp("answer byte", 16'(eq[i]), 16'(rxq[i]));
    endtask : check_ans
    initial begin
        repeat (16) @(posedge ref_clk);
        cmp("idle busy", 16'h0, 16'(busy_ff));
        cmp("idle tx valid", 16'h0, 16'(tx_valid_ff));
        #1 resetn = 1'b1;
        // Table of requests, each answered once
        foreach (rows[r]) begin
            reg_addr_ok = rows[r].ok;
            send_req(16'(r) + 16'h0100, rows[r].unit, rows[r].fc, rows[r].addr, rows[r].qty, 16'h0006, 1'b0);
            wait_done(1'b1);
            check_ans(16'(r) + 16'h0100, rows[r].unit, rows[r].fc, rows[r].addr, rows[r].qty, rows[r].exc);
            $display("table row %0d done", r);
        end
        reg_addr_ok = 1'b1;
        send_req(16'h00aa, 8'h00, 8'h03, 16'h0000, 16'h0001, 16'h0006, 1'b1);
        wait_done(1'b0);
        cmp("broadcast bytes", 16'h0, 16'(rxq.size()));
        $display("broadcast test done");
        send_req(16'h00bb, 8'h00, 8'h03, 16'h0000, 16'h0001, 16'h0001, 1'b0);
        wait_done(1'b0);
        cmp("short length flag", 16'h1, 16'(frame_err_ff));
        cmp("short length bytes", 16'h0, 16'(rxq.size()));
        $display("bad length test done");
        send_req(16'h1234, 8'h00, 8'h03, 16'h0010, 16'h0001, 16'h0007, 1'b0);
        wait_done(1'b1);
        cmp("flag cleared", 16'h0, 16'(frame_err_ff));
        check_ans(16'h1234, 8'h00, 8'h03, 16'h0010, 16'h0001, EXC_ILL_VALUE);
        $display("pdu length test done");
        conclude();
    end
endmodule : test_mbs_adu_server
